// ### rtl/indexed_postbyte_ea_decoder.sv
// Addressing-mode sequencer: operand fetch and effective address forming
// Notes on behaviour
// - Implied mode fetches no address bytes; opcode carries everything.
// - Immediate operand is one or two bytes right after the opcode.
// - Extended address is the next two bytes, high first, absolute.
// - Postbyte 10011111 is extended indirect, +5 cycles, +2 bytes.
// - Direct address is page base high byte with one fetched low byte.
// - Reset clears the page base.
// - Direct mode has no indirect form; one address byte only.
// - Register mode byte after opcode selects registers to act on.
// - Bit 7 clear adds signed five-bit offset; one cycle, no bytes.
// - Bits 6..5 pick X, Y, U or S as pointer.
// - Eight and sixteen bit constant offsets.
// - Accumulator A, B, D offsets.
// - Auto step by one or two; by-one has no indirect.
// - PC relative eight or sixteen bit offset ignores bits 6..5.
// - Zero offset uses pointer unchanged.
// - Indexed type, variation and pointer all come from the postbyte.
// - Indirect forms read a 16-bit address at the computed location.
// - Offset forms leave pointer and accumulator alone.
`timescale 1ns/1ps
module indexed_postbyte_ea_decoder
(
	input  wire logic               mclk,          // Core clock
	input  wire logic               arst_n,        // Async reset, active low
	input  wire logic               start,         // Begin address phase, pulse
	input  wire ea_pkg::addr_mode_t mode,          // Mode from the opcode
	input  wire logic               wide,          // Immediate operand is 16 bits
	input  wire logic [15:0]        pc_next,       // Address of byte after opcode
	input  wire logic [15:0]        reg_x,         // First index register
	input  wire logic [15:0]        reg_y,         // Second index register
	input  wire logic [15:0]        reg_u,         // User stack pointer
	input  wire logic [15:0]        reg_s,         // Hardware stack pointer
	input  wire logic [7:0]         acc_a,         // Accumulator A
	input  wire logic [7:0]         acc_b,         // Accumulator B
	input  wire logic               page_wr,       // Load page base, pulse
	input  wire logic [7:0]         page_wdata,    // New page base
	output logic      [15:0]        mem_addr,      // Memory byte address
	output logic                    mem_rd,        // Memory read request
	input  wire logic [7:0]         mem_rdata,     // Memory read data
	input  wire logic               mem_ack,       // Read data valid, pulse
	output logic                    busy,          // Address phase in progress
	output logic                    done,          // Result ready, pulse
	output logic      [15:0]        ea,            // Effective address
	output logic      [15:0]        operand,       // Immediate operand
	output logic      [15:0]        next_pc,       // Address after operand bytes
	output logic      [7:0]         reg_select,    // Register mode selector byte
	output logic      [3:0]         extra_cycles,  // Added cycles, indexed
	output logic      [1:0]         extra_bytes,   // Added bytes, indexed
	output logic                    undefined,     // Postbyte or mode undefined
	output logic                    ptr_wr,        // Pointer write back, pulse
	output logic      [1:0]         ptr_wr_sel,    // Pointer to write back
	output logic      [15:0]        ptr_wr_data,   // Stepped pointer value
	output logic      [7:0]         page_base      // Current page base
);
	typedef enum logic [2:0] {st_idle, st_fetch, st_finish, st_decode, st_calc} state_t;
	typedef enum logic [1:0] {ph_operand, ph_post, ph_arg, ph_indirect} phase_t;

	state_t             state_ff, nxt_state;
	phase_t             phase_ff, nxt_phase;
	ea_pkg::addr_mode_t mode_ff, nxt_mode;
	logic [1:0]         remain_ff, nxt_remain;
	logic [15:0]        prog_ptr_ff, nxt_prog_ptr;
	logic [15:0]        ind_ptr_ff, nxt_ind_ptr;
	logic [15:0]        shift_ff, nxt_shift;
	logic [7:0]         postbyte_ff, nxt_postbyte;
	logic [15:0]        ea_ff, nxt_ea;
	logic [15:0]        operand_ff, nxt_operand;
	logic [7:0]         reg_select_ff, nxt_reg_select;
	logic [3:0]         cycles_ff, nxt_cycles;
	logic [1:0]         bytes_ff, nxt_bytes;
	logic               undefined_ff, nxt_undefined;
	logic               done_ff, nxt_done;
	logic               ptr_wr_ff, nxt_ptr_wr;
	logic [1:0]         ptr_sel_ff, nxt_ptr_sel;
	logic [15:0]        ptr_data_ff, nxt_ptr_data;
	logic [7:0]         page_base_ff;

	postbyte_if pb_bus ();

	// decoder sees only the latched postbyte
	assign pb_bus.postbyte = postbyte_ff;

	postbyte_decode u_decode
	(
		.pb (pb_bus.dec)
	);

	wire         is_pc_rel = (pb_bus.kind == ea_pkg::ix_pc8) || (pb_bus.kind == ea_pkg::ix_pc16);
	wire         is_step   = (pb_bus.kind == ea_pkg::ix_inc1) || (pb_bus.kind == ea_pkg::ix_inc2) ||
	                         (pb_bus.kind == ea_pkg::ix_dec1) || (pb_bus.kind == ea_pkg::ix_dec2);
	logic [15:0] ptr_val;
	logic [15:0] ea_sum;
	logic [15:0] ptr_new;

	assign ptr_val = (pb_bus.ptr_sel == 2'd0) ? reg_x :
	                 (pb_bus.ptr_sel == 2'd1) ? reg_y :
	                 (pb_bus.ptr_sel == 2'd2) ? reg_u : reg_s;

	// PC relative counts from the byte after the last offset byte
	wire  [15:0] adder_base = is_pc_rel ? prog_ptr_ff : ptr_val;

	ea_adder u_adder
	(
		.kind  (pb_bus.kind),
		.base  (adder_base),
		.off5  (postbyte_ff[4:0]),
		.arg   (shift_ff),
		.acc_a (acc_a),
		.acc_b (acc_b),
		.sum   (ea_sum)
	);

	// Post increment: address is the old pointer, new value is stepped
	assign ptr_new = (pb_bus.kind == ea_pkg::ix_inc1) ? ptr_val + 16'h0001 :
	                 (pb_bus.kind == ea_pkg::ix_inc2) ? ptr_val + 16'h0002 : ea_sum;

	assign mem_addr = (phase_ff == ph_indirect) ? ind_ptr_ff : prog_ptr_ff;
	assign mem_rd   = (state_ff == st_fetch);
	assign busy     = (state_ff != st_idle);

	always_comb
	begin
		nxt_state      = state_ff;
		nxt_phase      = phase_ff;
		nxt_mode       = mode_ff;
		nxt_remain     = remain_ff;
		nxt_prog_ptr   = prog_ptr_ff;
		nxt_ind_ptr    = ind_ptr_ff;
		nxt_shift      = shift_ff;
		nxt_postbyte   = postbyte_ff;
		nxt_ea         = ea_ff;
		nxt_operand    = operand_ff;
		nxt_reg_select = reg_select_ff;
		nxt_cycles     = cycles_ff;
		nxt_bytes      = bytes_ff;
		nxt_undefined  = undefined_ff;
		nxt_done       = 1'b0;
		nxt_ptr_wr     = 1'b0;
		nxt_ptr_sel    = ptr_sel_ff;
		nxt_ptr_data   = ptr_data_ff;
		unique case (state_ff)
			st_idle:
				if (start)
				begin
					nxt_mode      = mode;
					nxt_prog_ptr  = pc_next;
					nxt_shift     = 16'h0000;
					nxt_cycles    = 4'h0;
					nxt_bytes     = 2'd0;
					nxt_undefined = 1'b0;
					nxt_phase     = ph_operand;
					nxt_state     = st_fetch;
					nxt_remain    = 2'd1;
					case (mode)
						ea_pkg::am_implied:
						begin
							nxt_ea    = 16'h0000;
							nxt_done  = 1'b1;
							nxt_state = st_idle;
						end
						ea_pkg::am_immediate:
						begin
							nxt_ea     = pc_next;
							nxt_remain = wide ? 2'd2 : 2'd1;
						end
						ea_pkg::am_extended:  nxt_remain = 2'd2;
						ea_pkg::am_direct:    nxt_remain = 2'd1;
						ea_pkg::am_register:  nxt_remain = 2'd1;
						ea_pkg::am_indexed:   nxt_phase  = ph_post;
						default:
						begin
							nxt_undefined = 1'b1;
							nxt_done      = 1'b1;
							nxt_state     = st_idle;
						end
					endcase
				end
			st_fetch:
				if (mem_ack)
				begin
					// High byte arrives first and shifts up
					nxt_shift  = {shift_ff[7:0], mem_rdata};
					nxt_remain = remain_ff - 2'd1;
					if (phase_ff == ph_indirect)
						nxt_ind_ptr = ind_ptr_ff + 16'h0001;
					else
						nxt_prog_ptr = prog_ptr_ff + 16'h0001;
					if (remain_ff == 2'd1)
						nxt_state = st_finish;
				end
			st_finish:
			begin
				nxt_state = st_idle;
				nxt_done  = 1'b1;
				if (phase_ff == ph_indirect)
					nxt_ea = shift_ff;
				else if (phase_ff == ph_post)
				begin
					nxt_postbyte = shift_ff[7:0];
					nxt_done     = 1'b0;
					nxt_state    = st_decode;
				end
				else if (phase_ff == ph_arg)
				begin
					nxt_done  = 1'b0;
					nxt_state = st_calc;
				end
				else
					case (mode_ff)
						ea_pkg::am_immediate: nxt_operand = shift_ff;
						ea_pkg::am_extended:  nxt_ea = shift_ff;
						// page base plus one byte, never indirect
						ea_pkg::am_direct:    nxt_ea = {page_base_ff, shift_ff[7:0]};
						ea_pkg::am_register:  nxt_reg_select = shift_ff[7:0];
						default:              nxt_undefined = 1'b1;
					endcase
			end
			st_decode:
			begin
				nxt_cycles    = pb_bus.cycles;
				nxt_bytes     = pb_bus.arg_bytes;
				nxt_undefined = pb_bus.illegal;
				nxt_shift     = 16'h0000;
				if (pb_bus.arg_bytes == 2'd0)
					nxt_state = st_calc;
				else
				begin
					nxt_remain = pb_bus.arg_bytes;
					nxt_phase  = ph_arg;
					nxt_state  = st_fetch;
				end
			end
			st_calc:
			begin
				// only auto step writes the pointer back
				if (is_step)
				begin
					nxt_ptr_wr   = 1'b1;
					nxt_ptr_sel  = pb_bus.ptr_sel;
					nxt_ptr_data = ptr_new;
				end
				if (pb_bus.kind == ea_pkg::ix_extind || pb_bus.indirect)
				begin
					nxt_ind_ptr = (pb_bus.kind == ea_pkg::ix_extind) ? shift_ff : ea_sum;
					nxt_shift   = 16'h0000;
					nxt_remain  = 2'd2;
					nxt_phase   = ph_indirect;
					nxt_state   = st_fetch;
				end
				else
				begin
					// direct sum of pointer and offset
					nxt_ea    = ea_sum;
					nxt_done  = 1'b1;
					nxt_state = st_idle;
				end
			end
		endcase
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			state_ff      <= st_idle;
			phase_ff      <= ph_operand;
			mode_ff       <= ea_pkg::am_implied;
			remain_ff     <= 2'd0;
			prog_ptr_ff   <= 16'h0000;
			ind_ptr_ff    <= 16'h0000;
			shift_ff      <= 16'h0000;
			postbyte_ff   <= 8'h00;
			ea_ff         <= 16'h0000;
			operand_ff    <= 16'h0000;
			reg_select_ff <= 8'h00;
		end
		else
		begin
			state_ff      <= nxt_state;
			phase_ff      <= nxt_phase;
			mode_ff       <= nxt_mode;
			remain_ff     <= nxt_remain;
			prog_ptr_ff   <= nxt_prog_ptr;
			ind_ptr_ff    <= nxt_ind_ptr;
			shift_ff      <= nxt_shift;
			postbyte_ff   <= nxt_postbyte;
			ea_ff         <= nxt_ea;
			operand_ff    <= nxt_operand;
			reg_select_ff <= nxt_reg_select;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			cycles_ff    <= 4'h0;
			bytes_ff     <= 2'd0;
			undefined_ff <= 1'b0;
			done_ff      <= 1'b0;
			ptr_wr_ff    <= 1'b0;
			ptr_sel_ff   <= 2'd0;
			ptr_data_ff  <= 16'h0000;
		end
		else
		begin
			cycles_ff    <= nxt_cycles;
			bytes_ff     <= nxt_bytes;
			undefined_ff <= nxt_undefined;
			done_ff      <= nxt_done;
			ptr_wr_ff    <= nxt_ptr_wr;
			ptr_sel_ff   <= nxt_ptr_sel;
			ptr_data_ff  <= nxt_ptr_data;
		end
	end

	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
			page_base_ff <= ea_pkg::PAGE_BASE_RESET;
		else if (page_wr)
			page_base_ff <= page_wdata;
	end

	assign done         = done_ff;
	assign ea           = ea_ff;
	assign operand      = operand_ff;
	assign next_pc      = prog_ptr_ff;
	assign reg_select   = reg_select_ff;
	assign extra_cycles = cycles_ff;
	assign extra_bytes  = bytes_ff;
	assign undefined    = undefined_ff;
	assign ptr_wr       = ptr_wr_ff;
	assign ptr_wr_sel   = ptr_sel_ff;
	assign ptr_wr_data  = ptr_data_ff;
	assign page_base    = page_base_ff;
endmodule // indexed_postbyte_ea_decoder

// ### rtl/ea_pkg.sv
// Shared types and constants for the addressing-mode front end
package ea_pkg;
	typedef enum logic [2:0] {
		am_implied, am_immediate, am_extended, am_direct, am_register, am_indexed
	} addr_mode_t;

	typedef enum logic [3:0] {
		ix_off5, ix_zero, ix_off8, ix_off16, ix_acca, ix_accb, ix_accd,
		ix_inc1, ix_inc2, ix_dec1, ix_dec2, ix_pc8, ix_pc16, ix_extind, ix_bad
	} ix_kind_t;

	// Postbyte fields
	localparam int        PB_FORM_BIT  = 7;
	localparam int        PB_IND_BIT   = 4;
	localparam int        PB_SEL_HI    = 6;
	localparam int        PB_SEL_LO    = 5;
	localparam logic [7:0] PB_EXT_IND  = 8'h9f;

	// Mode field codes, postbyte bits 3..0
	localparam logic [3:0] MD_INC1  = 4'h0;
	localparam logic [3:0] MD_INC2  = 4'h1;
	localparam logic [3:0] MD_DEC1  = 4'h2;
	localparam logic [3:0] MD_DEC2  = 4'h3;
	localparam logic [3:0] MD_ZERO  = 4'h4;
	localparam logic [3:0] MD_ACCB  = 4'h5;
	localparam logic [3:0] MD_ACCA  = 4'h6;
	localparam logic [3:0] MD_OFF8  = 4'h8;
	localparam logic [3:0] MD_OFF16 = 4'h9;
	localparam logic [3:0] MD_ACCD  = 4'hb;
	localparam logic [3:0] MD_PC8   = 4'hc;
	localparam logic [3:0] MD_PC16  = 4'hd;
	localparam logic [3:0] MD_EXT   = 4'hf;

	localparam logic [7:0] PAGE_BASE_RESET = 8'h00;

	// Extra cycles per indexed variation
	localparam logic [3:0] CYC_ZERO      = 4'h0;
	localparam logic [3:0] CYC_ZERO_IND  = 4'h3;
	localparam logic [3:0] CYC_OFF5      = 4'h1;
	localparam logic [3:0] CYC_OFF8      = 4'h1;
	localparam logic [3:0] CYC_OFF8_IND  = 4'h4;
	localparam logic [3:0] CYC_OFF16     = 4'h4;
	localparam logic [3:0] CYC_OFF16_IND = 4'h7;
	localparam logic [3:0] CYC_ACC8      = 4'h1;
	localparam logic [3:0] CYC_ACC8_IND  = 4'h4;
	localparam logic [3:0] CYC_ACCD      = 4'h4;
	localparam logic [3:0] CYC_ACCD_IND  = 4'h7;
	localparam logic [3:0] CYC_STEP1     = 4'h2;
	localparam logic [3:0] CYC_STEP2     = 4'h3;
	localparam logic [3:0] CYC_STEP2_IND = 4'h6;
	localparam logic [3:0] CYC_PC8       = 4'h1;
	localparam logic [3:0] CYC_PC8_IND   = 4'h4;
	localparam logic [3:0] CYC_PC16      = 4'h5;
	localparam logic [3:0] CYC_PC16_IND  = 4'h8;
	localparam logic [3:0] CYC_EXT_IND   = 4'h5;
endpackage

// ### rtl/postbyte_if.sv
// Postbyte and its decoded fields, between the sequencer and the decoder
`timescale 1ns/1ps
interface postbyte_if;
	logic [7:0]       postbyte;
	ea_pkg::ix_kind_t kind;
	logic [1:0]       ptr_sel;
	logic             indirect;
	logic [1:0]       arg_bytes;
	logic [3:0]       cycles;
	logic             illegal;

	modport dec (input postbyte, output kind, ptr_sel, indirect, arg_bytes, cycles, illegal);
	modport user (output postbyte, input kind, ptr_sel, indirect, arg_bytes, cycles, illegal);
endinterface

// ### rtl/postbyte_decode.sv
// Combinational decoder for the indexed postbyte
`timescale 1ns/1ps
module postbyte_decode
(
	postbyte_if.dec pb // Postbyte in, fields out
);
	wire       form5 = ~pb.postbyte[ea_pkg::PB_FORM_BIT];
	wire       ind   = pb.postbyte[ea_pkg::PB_IND_BIT] & ~form5;
	wire [3:0] md    = pb.postbyte[3:0];

	assign pb.ptr_sel  = pb.postbyte[ea_pkg::PB_SEL_HI:ea_pkg::PB_SEL_LO];
	assign pb.indirect = ind;
	assign pb.illegal  = (pb.kind == ea_pkg::ix_bad);

	always_comb
	begin
		pb.kind      = ea_pkg::ix_bad;
		pb.arg_bytes = 2'd0;
		pb.cycles    = 4'h0;
		if (form5)
		begin
			pb.kind   = ea_pkg::ix_off5;
			pb.cycles = ea_pkg::CYC_OFF5;
		end
		else
		begin
			case (md)
				// auto step, by-one has no indirect form
				ea_pkg::MD_INC1: begin pb.kind = ind ? ea_pkg::ix_bad : ea_pkg::ix_inc1;
					pb.cycles = ea_pkg::CYC_STEP1; end
				ea_pkg::MD_DEC1: begin pb.kind = ind ? ea_pkg::ix_bad : ea_pkg::ix_dec1;
					pb.cycles = ea_pkg::CYC_STEP1; end
				ea_pkg::MD_INC2: begin pb.kind = ea_pkg::ix_inc2;
					pb.cycles = ind ? ea_pkg::CYC_STEP2_IND : ea_pkg::CYC_STEP2; end
				ea_pkg::MD_DEC2: begin pb.kind = ea_pkg::ix_dec2;
					pb.cycles = ind ? ea_pkg::CYC_STEP2_IND : ea_pkg::CYC_STEP2; end
				ea_pkg::MD_ZERO: begin pb.kind = ea_pkg::ix_zero;
					pb.cycles = ind ? ea_pkg::CYC_ZERO_IND : ea_pkg::CYC_ZERO; end
				ea_pkg::MD_ACCA: begin pb.kind = ea_pkg::ix_acca;
					pb.cycles = ind ? ea_pkg::CYC_ACC8_IND : ea_pkg::CYC_ACC8; end
				ea_pkg::MD_ACCB: begin pb.kind = ea_pkg::ix_accb;
					pb.cycles = ind ? ea_pkg::CYC_ACC8_IND : ea_pkg::CYC_ACC8; end
				ea_pkg::MD_ACCD: begin pb.kind = ea_pkg::ix_accd;
					pb.cycles = ind ? ea_pkg::CYC_ACCD_IND : ea_pkg::CYC_ACCD; end
				ea_pkg::MD_OFF8: begin pb.kind = ea_pkg::ix_off8; pb.arg_bytes = 2'd1;
					pb.cycles = ind ? ea_pkg::CYC_OFF8_IND : ea_pkg::CYC_OFF8; end
				ea_pkg::MD_OFF16: begin pb.kind = ea_pkg::ix_off16; pb.arg_bytes = 2'd2;
					pb.cycles = ind ? ea_pkg::CYC_OFF16_IND : ea_pkg::CYC_OFF16; end
				ea_pkg::MD_PC8: begin pb.kind = ea_pkg::ix_pc8; pb.arg_bytes = 2'd1;
					pb.cycles = ind ? ea_pkg::CYC_PC8_IND : ea_pkg::CYC_PC8; end
				ea_pkg::MD_PC16: begin pb.kind = ea_pkg::ix_pc16; pb.arg_bytes = 2'd2;
					pb.cycles = ind ? ea_pkg::CYC_PC16_IND : ea_pkg::CYC_PC16; end
				ea_pkg::MD_EXT: begin
					pb.kind      = (pb.postbyte == ea_pkg::PB_EXT_IND) ?
						ea_pkg::ix_extind : ea_pkg::ix_bad;
					pb.arg_bytes = 2'd2;
					pb.cycles    = ea_pkg::CYC_EXT_IND;
				end
				default: pb.kind = ea_pkg::ix_bad;
			endcase
		end
	end
endmodule // postbyte_decode

// ### rtl/ea_adder.sv
// Offset selection, sign extension and 16-bit address sum
`timescale 1ns/1ps
module ea_adder
(
	input  wire ea_pkg::ix_kind_t kind,  // Decoded indexing variation
	input  wire logic [15:0]      base,  // Pointer or program counter
	input  wire logic [4:0]       off5,  // Offset held in the postbyte
	input  wire logic [15:0]      arg,   // Offset bytes after the postbyte
	input  wire logic [7:0]       acc_a, // Accumulator A
	input  wire logic [7:0]       acc_b, // Accumulator B
	output logic      [15:0]      sum    // Base plus offset
);
	logic [15:0] offset;

	always_comb
	begin
		unique case (kind)
			ea_pkg::ix_off5:                 offset = {{11{off5[4]}}, off5};
			ea_pkg::ix_off8, ea_pkg::ix_pc8: offset = {{8{arg[7]}}, arg[7:0]};
			ea_pkg::ix_off16, ea_pkg::ix_pc16: offset = arg;
			ea_pkg::ix_acca:                 offset = {{8{acc_a[7]}}, acc_a};
			ea_pkg::ix_accb:                 offset = {{8{acc_b[7]}}, acc_b};
			ea_pkg::ix_accd:                 offset = {acc_a, acc_b};
			ea_pkg::ix_dec1:                 offset = 16'hffff;
			ea_pkg::ix_dec2:                 offset = 16'hfffe;
			default:                         offset = 16'h0000;
		endcase
	end

	assign sum = base + offset;
endmodule // ea_adder

// ### verification/ea_assertions.sv
// Concurrent checks on the address sequencer ports
`timescale 1ns/1ps
module ea_assertions
(
	input wire logic               mclk,         // Core clock
	input wire logic               arst_n,       // Async reset
	input wire logic               start,        // Phase start
	input wire ea_pkg::addr_mode_t mode,         // Opcode mode
	input wire logic               wide,         // Two-byte immediate
	input wire logic [15:0]        pc_next,      // Byte after opcode
	input wire logic               page_wr,      // Page base load
	input wire logic [7:0]         page_wdata,   // New page base
	input wire logic               mem_rd,       // Read request
	input wire logic [7:0]         mem_rdata,    // Read data
	input wire logic               mem_ack,      // Read valid
	input wire logic               busy,         // Phase running
	input wire logic               done,         // Result pulse
	input wire logic [15:0]        ea,           // Effective address
	input wire logic [15:0]        next_pc,      // After operands
	input wire logic [7:0]         reg_select,   // Register selector
	input wire logic [3:0]         extra_cycles, // Indexed cycles
	input wire logic [1:0]         extra_bytes,  // Indexed bytes
	input wire logic               ptr_wr,       // Pointer write back
	input wire logic [1:0]         ptr_wr_sel,   // Pointer chosen
	input wire logic [7:0]         page_base     // Page base
);
	ea_pkg::addr_mode_t mode_ff;
	logic [15:0]        pc_ff;
	logic               wide_ff;
	logic               first_ff;
	logic [7:0]         pb_ff;
	wire                take = start && !busy;
	wire                got  = mem_rd && mem_ack;
	wire                ixd  = done && mode_ff == ea_pkg::am_indexed;
	// First byte after the opcode is the postbyte or selector
	always_ff @(posedge mclk)
	begin
		if (take)
		begin
			mode_ff <= mode;
			pc_ff <= pc_next;
			wide_ff <= wide;
		end
		if (first_ff && got)
			pb_ff <= mem_rdata;
		first_ff <= take || (first_ff && !got);
	end
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!arst_n);
	chk_implied_quick: assert property (take && mode == ea_pkg::am_implied |=> done && !mem_rd)
		else $error("implied slow");
	chk_imm_length: assert property (done && mode_ff == ea_pkg::am_immediate |->
		ea == pc_ff && next_pc == pc_ff + (wide_ff ? 16'h0002 : 16'h0001))
		else $error("imm length");
	chk_ext_bytes: assert property (done && mode_ff == ea_pkg::am_extended |->
		next_pc == pc_ff + 16'h0002 && extra_cycles == 4'h0)
		else $error("ext length");
	chk_ext_ind_cost: assert property (ixd && pb_ff == ea_pkg::PB_EXT_IND |->
		extra_cycles == 4'h5 && extra_bytes == 2'h2)
		else $error("ext ind cost");
	chk_direct_page: assert property (done && mode_ff == ea_pkg::am_direct |->
		ea[15:8] == page_base && next_pc == pc_ff + 16'h0001)
		else $error("direct page");
	chk_page_load: assert property (page_wr |=> page_base == $past(page_wdata))
		else $error("page load");
	chk_page_reset: assert property (!$past(arst_n) |-> page_base == 8'h00)
		else $error("page reset");
	chk_reg_selector: assert property (done && mode_ff == ea_pkg::am_register |->
		reg_select == pb_ff)
		else $error("reg select");
	chk_off5_cost: assert property (ixd && !pb_ff[7] |->
		extra_cycles == 4'h1 && extra_bytes == 2'h0)
		else $error("off5 cost");
	chk_step_wb: assert property (ixd && pb_ff[7] && pb_ff[4:0] == 5'h01 |->
		ptr_wr && ptr_wr_sel == pb_ff[6:5])
		else $error("step wb");
	chk_done_bound: assert property (take |-> ##[1:40] done)
		else $error("no done");
endmodule // ea_assertions
bind indexed_postbyte_ea_decoder ea_assertions ea_assertions_i (.mclk(mclk), .arst_n(arst_n),
	.start(start), .mode(mode), .wide(wide), .pc_next(pc_next), .page_wr(page_wr),
	.page_wdata(page_wdata), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_ack(mem_ack),
	.busy(busy), .done(done), .ea(ea), .next_pc(next_pc), .reg_select(reg_select),
	.extra_cycles(extra_cycles), .extra_bytes(extra_bytes), .ptr_wr(ptr_wr),
	.ptr_wr_sel(ptr_wr_sel), .page_base(page_base));

// ### verification/mem_model.sv
// Byte-wide program and data memory answering sequencer reads
`timescale 1ns/1ps
module mem_model
(
	input  wire logic        mclk,      // Core clock
	input  wire logic        arst_n,    // Async reset
	input  wire logic        slow,      // Stretch each read
	input  wire logic [15:0] mem_addr,  // Byte address
	input  wire logic        mem_rd,    // Read request
	output logic      [7:0]  mem_rdata, // Read data
	output logic             mem_ack    // Data valid pulse
);
	logic [7:0] mem [0:65535];
	logic [1:0] wait_ff;
	// Bus between acks toggles so stale data is never mistaken for valid
	always_ff @(posedge mclk or negedge arst_n)
	begin
		if (!arst_n)
		begin
			mem_ack <= 1'b0;
			mem_rdata <= 8'h00;
			wait_ff <= 2'h0;
		end
		else if (mem_rd && !mem_ack && wait_ff == (slow ? 2'h2 : 2'h0))
		begin
			mem_ack <= 1'b1;
			mem_rdata <= mem[mem_addr];
			wait_ff <= 2'h0;
		end
		else
		begin
			mem_ack <= 1'b0;
			mem_rdata <= ~mem_rdata;
			if (mem_rd && !mem_ack)
				wait_ff <= wait_ff + 2'h1;
		end
	end
endmodule // mem_model

// ### verification/tb.sv
// Self-checking bench for the addressing-mode sequencer
`timescale 1ns/1ps
module tb;
	localparam logic [15:0] P = 16'h2000;
	logic               mclk, arst_n, start, wide, page_wr, slow, mem_rd, mem_ack, busy, done;
	logic               undefined, ptr_wr, pw;
	ea_pkg::addr_mode_t mode;
	logic [15:0]        pc_next, reg_x, reg_y, reg_u, reg_s, mem_addr, ea, operand;
	logic [15:0]        next_pc, ptr_wr_data, pwd;
	logic [7:0]         acc_a, acc_b, page_wdata, mem_rdata, reg_select, page_base;
	logic [3:0]         extra_cycles;
	logic [1:0]         extra_bytes, ptr_wr_sel;
	int                 mismatches, samples_checked, cycles;
	indexed_postbyte_ea_decoder indexed_postbyte_ea_decoder_i (.mclk(mclk), .arst_n(arst_n),
		.start(start), .mode(mode), .wide(wide), .pc_next(pc_next), .reg_x(reg_x),
		.reg_y(reg_y), .reg_u(reg_u), .reg_s(reg_s), .acc_a(acc_a), .acc_b(acc_b),
		.page_wr(page_wr), .page_wdata(page_wdata), .mem_addr(mem_addr), .mem_rd(mem_rd),
		.mem_rdata(mem_rdata), .mem_ack(mem_ack), .busy(busy), .done(done), .ea(ea),
		.operand(operand), .next_pc(next_pc), .reg_select(reg_select),
		.extra_cycles(extra_cycles), .extra_bytes(extra_bytes), .undefined(undefined),
		.ptr_wr(ptr_wr), .ptr_wr_sel(ptr_wr_sel), .ptr_wr_data(ptr_wr_data),
		.page_base(page_base));
	mem_model mem_model_i (.mclk(mclk), .arst_n(arst_n), .slow(slow), .mem_addr(mem_addr),
		.mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_ack(mem_ack));
	initial
	begin
		mclk = 1'b0;
		forever #12.5 mclk = ~mclk;
	end
	always @(posedge mclk)
	begin
		cycles++;
		if (cycles == 5000)
		begin
			mismatches++;
			end_sim();
		end
	end
	task automatic end_sim();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		samples_checked++;
		if (g !== e)
		begin
			mismatches++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic poke(input logic [15:0] a, input logic [7:0] d);
		mem_model_i.mem[a] = d;
	endtask
	// Start held one cycle; done caught at a falling edge
	task automatic go(input ea_pkg::addr_mode_t m, input logic w);
		int n;
		mode = m;
		wide = w;
		pc_next = P;
		start = 1'b1;
		n = 0;
		do
		begin
			@(negedge mclk);
			start = 1'b0;
			n++;
		end
		while (done !== 1'b1 && n < 60);
		pw = ptr_wr;
		pwd = ptr_wr_data;
		chk("done", 16'h0001, {15'h0000, done});
	endtask
	task automatic ix(input logic [7:0] pb, b1, b2, input logic [15:0] e, input logic [3:0] c,
		input logic [1:0] b, input logic u);
		poke(P, pb);
		poke(P + 16'h0001, b1);
		poke(P + 16'h0002, b2);
		go(ea_pkg::am_indexed, 1'b0);
		chk("undefined", {15'h0000, u}, {15'h0000, undefined});
		if (!u)
		begin
			chk("ea", e, ea);
			chk("extra_cycles", {12'h000, c}, {12'h000, extra_cycles});
			chk("extra_bytes", {14'h0000, b}, {14'h0000, extra_bytes});
		end
	endtask
	initial
	begin
		{start, wide, page_wr, slow} = 4'h0;
		mode = ea_pkg::am_implied;
		pc_next = P;
		{reg_x, reg_y, reg_u, reg_s} = {16'h4000, 16'h5ff0, 16'h8000, 16'hfff8};
		{acc_a, acc_b, page_wdata} = {8'hf0, 8'h7f, 8'h00};
		arst_n = 1'b0;
		repeat (2) @(negedge mclk);
		arst_n = 1'b1;
		chk("page_base", 16'h0000, {8'h00, page_base});
		go(ea_pkg::am_implied, 1'b0);
		chk("ea", 16'h0000, ea);
		poke(P, 8'h12);
		poke(P + 16'h0001, 8'h34);
		go(ea_pkg::am_immediate, 1'b0);
		chk("operand", 16'h0012, operand);
		go(ea_pkg::am_immediate, 1'b1);
		chk("operand", 16'h1234, operand);
		slow = 1'b1;
		go(ea_pkg::am_extended, 1'b0);
		chk("ea", 16'h1234, ea);
		chk("next_pc", P + 16'h0002, next_pc);
		page_wdata = 8'h56;
		page_wr = 1'b1;
		@(negedge mclk);
		page_wr = 1'b0;
		go(ea_pkg::am_direct, 1'b0);
		chk("ea", 16'h5612, ea);
		go(ea_pkg::am_register, 1'b0);
		chk("reg_select", 16'h0012, {8'h00, reg_select});
		$display("test plain modes ended");
		slow = 1'b0;
		ix(8'h05, 8'h00, 8'h00, 16'h4005, 4'h1, 2'h0, 1'b0);
		ix(8'h3f, 8'h00, 8'h00, 16'h5fef, 4'h1, 2'h0, 1'b0);
		ix(8'ha4, 8'h00, 8'h00, 16'h5ff0, 4'h0, 2'h0, 1'b0);
		ix(8'hc8, 8'h80, 8'h00, 16'h7f80, 4'h1, 2'h1, 1'b0);
		ix(8'he9, 8'h00, 8'h10, 16'h0008, 4'h4, 2'h2, 1'b0);
		ix(8'h86, 8'h00, 8'h00, 16'h3ff0, 4'h1, 2'h0, 1'b0);
		ix(8'h85, 8'h00, 8'h00, 16'h407f, 4'h1, 2'h0, 1'b0);
		ix(8'h8b, 8'h00, 8'h00, 16'h307f, 4'h4, 2'h0, 1'b0);
		ix(8'h80, 8'h00, 8'h00, 16'h4000, 4'h2, 2'h0, 1'b0);
		chk("ptr_wr_data", 16'h4001, pwd);
		ix(8'h81, 8'h00, 8'h00, 16'h4000, 4'h3, 2'h0, 1'b0);
		chk("ptr_wr_data", 16'h4002, pwd);
		ix(8'h82, 8'h00, 8'h00, 16'h3fff, 4'h2, 2'h0, 1'b0);
		ix(8'h83, 8'h00, 8'h00, 16'h3ffe, 4'h3, 2'h0, 1'b0);
		chk("ptr_wr", 16'h0001, {15'h0000, pw});
		ix(8'hcc, 8'h10, 8'h00, 16'h2012, 4'h1, 2'h1, 1'b0);
		ix(8'h8d, 8'hff, 8'hf0, 16'h1ff3, 4'h5, 2'h2, 1'b0);
		$display("test direct indexing ended");
		slow = 1'b1;
		poke(16'h4000, 8'h12);
		poke(16'h4001, 8'h34);
		poke(16'h60f0, 8'h56);
		poke(16'h60f1, 8'h78);
		poke(16'h3000, 8'hab);
		poke(16'h3001, 8'hcd);
		ix(8'h94, 8'h00, 8'h00, 16'h1234, 4'h3, 2'h0, 1'b0);
		ix(8'h91, 8'h00, 8'h00, 16'h1234, 4'h6, 2'h0, 1'b0);
		ix(8'hb9, 8'h01, 8'h00, 16'h5678, 4'h7, 2'h2, 1'b0);
		ix(8'h9f, 8'h30, 8'h00, 16'habcd, 4'h5, 2'h2, 1'b0);
		ix(8'h90, 8'h00, 8'h00, 16'h0000, 4'h0, 2'h0, 1'b1);
		arst_n = 1'b0;
		@(negedge mclk);
		arst_n = 1'b1;
		chk("page_base", 16'h0000, {8'h00, page_base});
		$display("test indirect and reset ended");
		end_sim();
	end
endmodule // tb
